// ### src/port_pin_override_mux.sv
`timescale 1ns/10ps
// Summary of operation
// - Pull-up follows override, else pattern 010
// - Override value alone sets pull-up state
// - Driver enable from override or direction bit
// - Direction override beats direction bit
// - Driven value from override or latch
// - Value override ignores output latch bit
// - Toggle override enable inverts output latch
// - Input enable from override or sleep
// - Input override ignores sleep state
// - Raw pad sense unsynchronised to functions
// - Strobes per port, clamp and kill shared
// - Bit 7 outputs timer2 compare A
// - Bit 6 outputs timer1 compare B
// - Bit 5 outputs timer1 compare A
// - Bit 4 outputs timer0 compare A
// - Bit 3 MISO, master forces input
// - Forced input keeps latch-controlled pull-up
// - Bits 7..3 feed pin-change sources 15..11
// - Direction one drives latch level out when no value or direction override applies
// - Sleep clamp is default input gating
module port_pin_override_mux
    import pin_override_pkg::*;
#(
    parameter int unsigned PINS = PIN_COUNT
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire port_strobe_t         strobe,
    input  wire logic                 sleep_clamp,
    input  wire logic                 global_pullup_kill,
    input  wire logic                 pad_in_schmitt,
    input  wire logic [PINS-1:0]      pad_in,
    input  wire logic                 timer2_compare_a_en,
    input  wire logic                 timer2_compare_a_out,
    input  wire logic                 timer1_compare_b_en,
    input  wire logic                 timer1_compare_b_out,
    input  wire logic                 timer1_compare_a_en,
    input  wire logic                 timer1_compare_a_out,
    input  wire logic                 timer0_compare_a_en,
    input  wire logic                 timer0_compare_a_out,
    input  wire logic                 spi_enable,
    input  wire logic                 spi_master,
    input  wire logic                 spi_slave_out,
    input  wire logic [PINS-1:0]      pin_change_mask,
    input  wire logic                 pin_change_group_en,
    output logic [PINS-1:0]           pad_out,
    output logic [PINS-1:0]           pad_oe,
    output logic [PINS-1:0]           pad_pullup,
    output logic [PINS-1:0]           raw_pad_sense_to_function,
    output logic [PINS-1:0]           pin_change_source,
    output logic [PINS-1:0]           pin_direction_bit,
    output logic [PINS-1:0]           pin_output_latch_bit,
    output logic [PINS-1:0]           pin_input_sample_bit
);

    // Pin map below is fixed to bits 7..3, so no other width can work
    if (PINS != PIN_COUNT) begin : g_bad_pins
        $error("PINS must equal the five mapped pins");
    end

    override_t [PINS-1:0] ovr;
    pad_ctrl_t [PINS-1:0] ctrl;
    logic      [PINS-1:0] dir_q;
    logic      [PINS-1:0] latch_q;
    logic      [PINS-1:0] latch_d;
    logic      [PINS-1:0] sync_q;
    logic      [PINS-1:0] sample_q;
    logic      [PINS-1:0] gated_in;
    logic                 spi_master_on;

    // Shared port strobe slices: upper five wdata bits map bits 7..3
    logic [PINS-1:0] wdata_pins;
    assign wdata_pins = strobe.wdata[PORT_WIDTH-1:LOW_PIN];

    assign spi_master_on = spi_enable & spi_master;

    // Per-pin override requests, index 0 is bit 3
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            ovr[i] = '0;
            // Pin change sense keeps input alive in sleep
            ovr[i].input_enable_override_enable =
                pin_change_mask[i] & pin_change_group_en;
            ovr[i].input_enable_override_value = 1'b1;
        end
        // Timer outputs take value only; direction stays software's
        ovr[PIN_B7-LOW_PIN].port_value_override_enable =
            timer2_compare_a_en;
        ovr[PIN_B7-LOW_PIN].port_value_override_value =
            timer2_compare_a_out;
        ovr[PIN_B6-LOW_PIN].port_value_override_enable =
            timer1_compare_b_en;
        ovr[PIN_B6-LOW_PIN].port_value_override_value =
            timer1_compare_b_out;
        ovr[PIN_B5-LOW_PIN].port_value_override_enable =
            timer1_compare_a_en;
        ovr[PIN_B5-LOW_PIN].port_value_override_value =
            timer1_compare_a_out;
        ovr[PIN_B4-LOW_PIN].port_value_override_enable =
            timer0_compare_a_en;
        ovr[PIN_B4-LOW_PIN].port_value_override_value =
            timer0_compare_a_out;
        // Master forces input; slave leaves the direction bit in charge
        ovr[PIN_B3-LOW_PIN].direction_override_enable =
            spi_master_on;
        ovr[PIN_B3-LOW_PIN].direction_override_value = 1'b0;
        ovr[PIN_B3-LOW_PIN].pullup_override_enable = spi_master_on;
        ovr[PIN_B3-LOW_PIN].pullup_override_value =
            latch_q[PIN_B3-LOW_PIN] & ~global_pullup_kill;
        // Slave output driven once software sets direction
        ovr[PIN_B3-LOW_PIN].port_value_override_enable =
            spi_enable & ~spi_master;
        ovr[PIN_B3-LOW_PIN].port_value_override_value = spi_slave_out;
    end

    // Resolution is combinational so overrides hit the pad at once
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            ctrl[i].pullup_on = ovr[i].pullup_override_enable
                ? ovr[i].pullup_override_value
                : ({dir_q[i], latch_q[i], global_pullup_kill}
                   == PULLUP_PATTERN);
            ctrl[i].drive_enable = ovr[i].direction_override_enable
                ? ovr[i].direction_override_value
                : dir_q[i];
            ctrl[i].drive_value = ovr[i].port_value_override_enable
                ? ovr[i].port_value_override_value
                : latch_q[i];
            ctrl[i].input_enable = ovr[i].input_enable_override_enable
                ? ovr[i].input_enable_override_value
                : ~sleep_clamp;
        end
    end

    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            pad_oe[i]     = ctrl[i].drive_enable;
            pad_out[i]    = ctrl[i].drive_enable & ctrl[i].drive_value;
            pad_pullup[i] = ctrl[i].pullup_on & ~ctrl[i].drive_enable;
            // Clamp to ground ahead of the Schmitt trigger stage
            gated_in[i]   = pad_in[i] & ctrl[i].input_enable;
        end
    end

    // Unsynchronised; receivers add their own synchroniser
    assign raw_pad_sense_to_function = gated_in;
    assign pin_change_source         = gated_in;

    // Direction register, write strobe shared by the port
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dir_q <= {PINS{DIR_RESET}};
        end else if (strobe.dir_write) begin
            dir_q <= wdata_pins;
        end
    end

    // Writing ones to the sample register toggles the latch
    always_comb begin
        latch_d = latch_q;
        if (strobe.latch_write) begin
            latch_d = wdata_pins;
        end else if (strobe.sample_write) begin
            latch_d = latch_q ^ wdata_pins;
        end
        for (int i = 0; i < PINS; i++) begin
            if (ovr[i].latch_invert_override_enable) begin
                latch_d[i] = ~latch_d[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            latch_q <= {PINS{LATCH_RESET}};
        end else begin
            latch_q <= latch_d;
        end
    end

    // Two-stage synchroniser into the sample register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync_q   <= '0;
            sample_q <= '0;
        end else begin
            sync_q   <= gated_in;
            sample_q <= sync_q;
        end
    end

    assign pin_direction_bit    = dir_q;
    assign pin_output_latch_bit = latch_q;
    assign pin_input_sample_bit = sample_q;

endmodule : port_pin_override_mux

// ### pkg/pin_override_pkg.sv
package pin_override_pkg;

    // Port B upper pins handled here: bit 7 down to bit 3
    localparam int unsigned PIN_COUNT      = 5;
    localparam int unsigned PORT_WIDTH     = 8;
    localparam int unsigned LOW_PIN        = 3;
    localparam int unsigned PIN_B7         = 7;
    localparam int unsigned PIN_B6         = 6;
    localparam int unsigned PIN_B5         = 5;
    localparam int unsigned PIN_B4         = 4;
    localparam int unsigned PIN_B3         = 3;
    localparam int unsigned PCSRC_BASE     = 8;
    localparam logic [2:0]  PULLUP_PATTERN = 3'b010;
    localparam logic        LATCH_RESET    = 1'b0;
    localparam logic        DIR_RESET      = 1'b0;

    // Override request from one alternate function for one pin
    typedef struct packed {
        logic pullup_override_enable;
        logic pullup_override_value;
        logic direction_override_enable;
        logic direction_override_value;
        logic port_value_override_enable;
        logic port_value_override_value;
        logic latch_invert_override_enable;
        logic input_enable_override_enable;
        logic input_enable_override_value;
    } override_t;

    // Resolved pad controls for one pin
    typedef struct packed {
        logic pullup_on;
        logic drive_enable;
        logic drive_value;
        logic input_enable;
    } pad_ctrl_t;

    // Shared strobes of one port
    typedef struct packed {
        logic [PORT_WIDTH-1:0] wdata;
        logic                  dir_write;
        logic                  latch_write;
        logic                  sample_write;
    } port_strobe_t;

endpackage : pin_override_pkg

// ### verification/port_pin_override_mux_sva.sv
`timescale 1ns/10ps
module pin_mux_checker
    import pin_override_pkg::*;
#(
    parameter int unsigned PINS = PIN_COUNT
) (
    input wire logic            ref_clk,
    input wire logic            rst_n,
    input wire port_strobe_t    strobe,
    input wire logic            sleep_clamp,
    input wire logic            global_pullup_kill,
    input wire logic [PINS-1:0] pad_in,
    input wire logic            timer2_compare_a_en,
    input wire logic            timer2_compare_a_out,
    input wire logic            spi_enable,
    input wire logic            spi_master,
    input wire logic [PINS-1:0] pin_change_mask,
    input wire logic            pin_change_group_en,
    input wire logic [PINS-1:0] pad_out,
    input wire logic [PINS-1:0] pad_oe,
    input wire logic [PINS-1:0] pad_pullup,
    input wire logic [PINS-1:0] raw_pad_sense_to_function,
    input wire logic [PINS-1:0] pin_direction_bit,
    input wire logic [PINS-1:0] pin_output_latch_bit,
    input wire logic [PINS-1:0] pin_input_sample_bit
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [PINS-1:0] wd;
    logic [PINS-1:0] ie;
    logic [PINS-1:0] pu;
    logic            fsm;
    assign wd  = strobe.wdata[LOW_PIN+PINS-1:LOW_PIN];
    assign ie  = pin_change_mask & {PINS{pin_change_group_en}};
    assign pu  = ~pin_direction_bit & pin_output_latch_bit
                 & {PINS{!global_pullup_kill}};
    assign fsm = spi_enable & spi_master;
    sequence dir_wr_s; strobe.dir_write; endsequence
    // Sync flops only trustworthy after three clean awake edges
    sequence awake_s; (rst_n && !sleep_clamp)[*3]; endsequence
    dir_load_a: assert property (
        dir_wr_s |=> pin_direction_bit == $past(wd)) else $error("dir load");
    oe_from_dir_a: assert property (
        pad_oe[PINS-1:1] == pin_direction_bit[PINS-1:1]) else $error("oe");
    miso_input_a: assert property (
        fsm |-> !pad_oe[0]) else $error("miso not input");
    pvo_value_a: assert property (
        timer2_compare_a_en && pad_oe[PINS-1]
        |-> pad_out[PINS-1] == timer2_compare_a_out) else $error("pvo");
    pullup_pattern_a: assert property (
        !fsm |-> pad_pullup == pu) else $error("pullup");
    forced_pullup_a: assert property (
        fsm |-> pad_pullup[0] == (pin_output_latch_bit[0]
        && !global_pullup_kill)) else $error("forced pullup");
    input_gate_a: assert property (
        raw_pad_sense_to_function == (pad_in & (ie | {PINS{!sleep_clamp}})))
        else $error("input gate");
    sync_delay_a: assert property (
        awake_s |-> pin_input_sample_bit == $past(pad_in, 2))
        else $error("sync delay");
endmodule : pin_mux_checker

bind port_pin_override_mux pin_mux_checker #(.PINS(PINS)) i_pin_mux_checker (
    .ref_clk, .rst_n, .strobe, .sleep_clamp, .global_pullup_kill, .pad_in,
    .timer2_compare_a_en, .timer2_compare_a_out, .spi_enable, .spi_master,
    .pin_change_mask, .pin_change_group_en, .pad_out, .pad_oe, .pad_pullup,
    .raw_pad_sense_to_function, .pin_direction_bit, .pin_output_latch_bit,
    .pin_input_sample_bit);

// ### verification/pad_model.sv
`timescale 1ns/10ps
module pad_model (
    input  wire logic       ref_clk,
    input  wire logic [4:0] pad_out,
    input  wire logic [4:0] pad_oe,
    input  wire logic [4:0] pad_pullup,
    input  wire logic [4:0] ext_en,
    input  wire logic [4:0] ext_val,
    output logic      [4:0] level
);
    // Floating pad wanders so a stale level never passes
    logic [4:0] float_q = 5'h0a;
    always_ff @(posedge ref_clk) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (pad_oe[i]) level[i] = pad_out[i];
            else if (ext_en[i]) level[i] = ext_val[i];
            else if (pad_pullup[i]) level[i] = 1'b1;
            else level[i] = float_q[i];
        end
    end
endmodule : pad_model

// ### verification/port_pin_override_mux_bench.sv
`timescale 1ns/10ps
module port_pin_override_mux_bench;
    import pin_override_pkg::*;
    logic         ref_clk = 1'b0;
    logic         rst_n = 1'b0;
    port_strobe_t st = '0;
    logic         sl = 1'b0;
    logic         kill = 1'b0;
    logic         grp = 1'b0;
    logic [3:0]   t_en = '0;
    logic [3:0]   t_out = '0;
    logic [2:0]   spi = '0;
    logic [4:0]   mask = '0;
    logic [4:0]   x_en = '0;
    logic [4:0]   x_val = '0;
    logic [4:0]   p_in, p_out, p_oe, p_pu, raw, pcs, dir, smp, lat;
    int           bad_count = 0;
    int           n_checks = 0;
    initial forever #20 ref_clk = ~ref_clk;
    port_pin_override_mux i_port_pin_override_mux (.ref_clk, .rst_n,
        .strobe(st), .sleep_clamp(sl), .global_pullup_kill(kill),
        .pad_in_schmitt(1'b0), .pad_in(p_in), .timer2_compare_a_en(t_en[3]),
        .timer2_compare_a_out(t_out[3]), .timer1_compare_b_en(t_en[2]),
        .timer1_compare_b_out(t_out[2]), .timer1_compare_a_en(t_en[1]),
        .timer1_compare_a_out(t_out[1]), .timer0_compare_a_en(t_en[0]),
        .timer0_compare_a_out(t_out[0]), .spi_enable(spi[2]),
        .spi_master(spi[1]), .spi_slave_out(spi[0]), .pin_change_mask(mask),
        .pin_change_group_en(grp), .pad_out(p_out), .pad_oe(p_oe),
        .pad_pullup(p_pu), .raw_pad_sense_to_function(raw),
        .pin_change_source(pcs), .pin_direction_bit(dir),
        .pin_output_latch_bit(lat), .pin_input_sample_bit(smp));
    pad_model i_pad_model (.ref_clk, .pad_out(p_out), .pad_oe(p_oe),
        .pad_pullup(p_pu), .ext_en(x_en), .ext_val(x_val), .level(p_in));
    task automatic step(int n = 1);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : step
    task automatic chk(logic [4:0] seen, logic [4:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Back to back direction then latch write
    task automatic wr(logic [7:0] d, logic [7:0] l);
        st = {d, 3'b100};
        step();
        st = {l, 3'b010};
        step();
        st = '0;
        step();
    endtask : wr
    task automatic t_gpio();
        wr(8'h00, 8'hf8);
        chk(p_pu, 5'h1f);
        chk(p_oe, 5'h00);
        kill = 1'b1;
        #1 chk(p_pu, 5'h00);
        kill = 1'b0;
        wr(8'ha8, 8'h68);
        chk(p_oe, 5'h15);
        chk(p_out, 5'h05);
        chk(p_pu, 5'h08);
        chk(dir, 5'h15);
        chk(lat, 5'h0d);
        // Ones on the sample strobe toggle the latch
        st = {8'hf8, 3'b001};
        step();
        st = '0;
        step();
        chk(lat, 5'h12);
        // Latch write beats sample write in one cycle
        st = {8'h50, 3'b011};
        step();
        st = '0;
        step();
        chk(lat, 5'h0a);
        $display("gpio done");
    endtask : t_gpio
    task automatic t_timer();
        wr(8'hff, 8'h00);
        t_en = 4'hf;
        for (int i = 0; i < 4; i++) begin
            t_out = 4'(i) ^ 4'h5;
            step();
            chk(p_out, {t_out, 1'b0});
        end
        wr(8'hff, 8'hff);
        t_out = 4'h0;
        #1 chk(p_out, 5'h01);
        t_en = 4'h0;
        #1 chk(p_out, 5'h1f);
        t_en = 4'hf;
        wr(8'h00, 8'h00);
        chk(p_oe, 5'h00);
        t_en = 4'h0;
        $display("timer done");
    endtask : t_timer
    task automatic t_spi();
        wr(8'h08, 8'h08);
        spi = 3'b110;
        #1 chk(p_oe, 5'h00);
        chk(p_pu, 5'h01);
        kill = 1'b1;
        #1 chk(p_pu, 5'h00);
        kill = 1'b0;
        spi = 3'b101;
        #1 chk(p_oe, 5'h01);
        chk(p_out, 5'h01);
        // Slave output low while latch is high shows the override
        spi = 3'b100;
        #1 chk(p_out, 5'h00);
        spi = 3'b000;
        $display("spi done");
    endtask : t_spi
    task automatic t_input();
        wr(8'h00, 8'h00);
        {x_en, x_val, sl, mask, grp} = {5'h1f, 5'h16, 1'b1, 5'h03, 1'b1};
        #1 chk(raw, 5'h02);
        chk(pcs, 5'h02);
        grp = 1'b0;
        #1 chk(raw, 5'h00);
        sl = 1'b0;
        #1 chk(raw, 5'h16);
        step(3);
        chk(smp, 5'h16);
        $display("input done");
    endtask : t_input
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial begin
        step(20);
        rst_n = 1'b1;
        t_gpio();
        t_timer();
        t_spi();
        t_input();
        results();
    end
    initial begin
        step(2000);
        bad_count++;
        results();
    end
endmodule : port_pin_override_mux_bench
